// ==== logic/ustc_core.sv ====
module ustc_core
  import ustc_pkg::*;
#(
  parameter int CLKS_PER_BIT = CLKS_PER_BIT_DEF
)
(
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial line
  input wire logic serial_rx_pin,
  output logic serial_tx_pin_o,
  output logic serial_tx_pin_oe,
  // event pulses
  output logic tx_irq_o,
  output logic rx_irq_o
);

  localparam int CW = $clog2(FIFO_DEPTH) + 1;
  localparam logic [15:0] TICK_LAST = 16'(CLKS_PER_BIT - 1);
  localparam logic [15:0] HALF_LAST = 16'(CLKS_PER_BIT / 2 - 1);
  localparam logic [15:0] IR_CLKS = 16'((CLKS_PER_BIT * IR_PULSE_NUM + IR_PULSE_DEN - 1)
                                        / IR_PULSE_DEN);

  if (CLKS_PER_BIT < 4 || CLKS_PER_BIT > 65535)
  begin : g_bad_rate
    $error("ustc_core: CLKS_PER_BIT must lie in 4..65535");
  end

  logic [1:0] txmode_q, rxmode_q, fmt_q;
  logic txpol_q, brk_q, txen_q, address_detect_enable_q, overrun_flag_q, infrared_codec_enable_q;
  logic [31:0] prdata_q;
  logic [15:0] status_w;
  logic setup, acc, addr_ok, wr_st, wr_mode, wr_tx, rd_rx;
  logic fmt9, par_en, odd;
  logic [8:0] tx_head;
  logic [CW-1:0] tx_count, rx_count, rx_cnt_next;
  logic tx_full, tx_empty, tx_push, tx_pop, tx_start, tx_tick, tx_stop_end, brk_done;
  ustc_tx_state_e tx_st_q;
  logic [15:0] tx_tmr_q, rx_tmr_q;
  logic [3:0] tx_cnt_q, rx_cnt_q, tx_last, rx_last;
  logic [8:0] tx_sh_q, rx_sh_q;
  logic tx_par_q, brk_frame_q, tx_bit, tx_pin_q, tx_irq_d, tx_irq_q;
  ustc_rx_state_e rx_st_q;
  logic [10:0] rx_head;
  logic rx_full, rx_empty, rx_tick, rx_half, rx_done, rx_keep, rx_push, rx_pop;
  logic rx_parity_error_flag_q, ovf_evt, overrun_flag_clr, rx_irq_d, rx_irq_q;

  // apb decode: zero wait states, read data captured in the setup cycle
  assign setup = psel & ~penable;
  assign acc = psel & penable;
  assign addr_ok = paddr == ADDR_STATUS || paddr == ADDR_MODE ||
                   paddr == ADDR_TXDATA || paddr == ADDR_RXDATA;
  assign wr_st = acc & pwrite & (paddr == ADDR_STATUS);
  assign wr_mode = acc & pwrite & (paddr == ADDR_MODE);
  assign wr_tx = acc & pwrite & (paddr == ADDR_TXDATA);
  assign rd_rx = acc & ~pwrite & (paddr == ADDR_RXDATA);
  assign pready = 1'b1;
  assign pslverr = acc & ~addr_ok;
  assign prdata = prdata_q;

  // status word; the reserved bit reads as zero
  always_comb
  begin
    status_w = 16'h0000;
    status_w[BIT_TXMODE1] = txmode_q[1];
    status_w[BIT_TXPOL] = txpol_q;
    status_w[BIT_TXMODE0] = txmode_q[0];
    status_w[BIT_TXBRK] = brk_q;
    status_w[BIT_TXEN] = txen_q;
    status_w[BIT_TXFULL] = tx_full;
    status_w[BIT_TXEMPTY] = (tx_st_q == TX_IDLE) & tx_empty;
    status_w[BIT_RXMODE1] = rxmode_q[1];
    status_w[BIT_RXMODE0] = rxmode_q[0];
    status_w[BIT_ADDRESS_DETECT_ENABLE] = address_detect_enable_q;
    status_w[BIT_RX_IDLE_FLAG] = rx_st_q == RX_IDLE;
    status_w[BIT_PARITY_ERROR_FLAG] = ~rx_empty & rx_head[10];
    status_w[BIT_FRAMING_ERROR_FLAG] = ~rx_empty & rx_head[9];
    status_w[BIT_OVERRUN_FLAG] = overrun_flag_q;
    status_w[BIT_RXDA] = ~rx_empty;
  end

  // read mux, registered so prdata is stable for the whole access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_q <= 32'h00000000;
    else if (setup)
    begin
      case (paddr)
        ADDR_STATUS: prdata_q <= {16'h0000, status_w};
        ADDR_MODE: prdata_q <= {19'h00000, infrared_codec_enable_q, 9'h000, fmt_q, 1'b0};
        ADDR_RXDATA: prdata_q <= {23'h000000, rx_head[8:0]};
        default: prdata_q <= 32'h00000000;
      endcase
    end
  end

  // software control fields; hardware set of overrun wins over the clear
  assign overrun_flag_clr = wr_st & overrun_flag_q & ~pwdata[BIT_OVERRUN_FLAG] & ~ovf_evt;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      txmode_q <= {STATUS_CTRL_RST[BIT_TXMODE1], STATUS_CTRL_RST[BIT_TXMODE0]};
      txpol_q <= STATUS_CTRL_RST[BIT_TXPOL];
      brk_q <= STATUS_CTRL_RST[BIT_TXBRK];
      txen_q <= STATUS_CTRL_RST[BIT_TXEN];
      rxmode_q <= {STATUS_CTRL_RST[BIT_RXMODE1], STATUS_CTRL_RST[BIT_RXMODE0]};
      address_detect_enable_q <= STATUS_CTRL_RST[BIT_ADDRESS_DETECT_ENABLE];
      overrun_flag_q <= STATUS_CTRL_RST[BIT_OVERRUN_FLAG];
      infrared_codec_enable_q <= MODE_RST[BIT_INFRARED_CODEC_ENABLE];
      fmt_q <= {MODE_RST[BIT_FMT1], MODE_RST[BIT_FMT0]};
    end
    else
    begin
      if (wr_st)
      begin
        txmode_q <= {pwdata[BIT_TXMODE1], pwdata[BIT_TXMODE0]};
        txpol_q <= pwdata[BIT_TXPOL];
        txen_q <= pwdata[BIT_TXEN];
        rxmode_q <= {pwdata[BIT_RXMODE1], pwdata[BIT_RXMODE0]};
        address_detect_enable_q <= pwdata[BIT_ADDRESS_DETECT_ENABLE];
      end
      // a software write decides; otherwise the end of the break frame clears
      if (wr_st)
        brk_q <= pwdata[BIT_TXBRK];
      else if (brk_done)
        brk_q <= 1'b0;
      if (ovf_evt)
        overrun_flag_q <= 1'b1;
      else if (overrun_flag_clr)
        overrun_flag_q <= 1'b0;
      if (wr_mode)
      begin
        infrared_codec_enable_q <= pwdata[BIT_INFRARED_CODEC_ENABLE];
        fmt_q <= {pwdata[BIT_FMT1], pwdata[BIT_FMT0]};
      end
    end
  end

  assign fmt9 = fmt_q == FMT_9N;
  assign par_en = fmt_q == FMT_8E || fmt_q == FMT_8O;
  assign odd = fmt_q == FMT_8O;

  // transmit queue; held empty while transmit is disabled
  ustc_fifo #(.W(9), .DEPTH(FIFO_DEPTH)) u_txq (
    .clk(pclk),
    .rst_n(presetn),
    .flush(~txen_q),
    .push(tx_push),
    .wdata(pwdata[8:0]),
    .pop(tx_pop),
    .rdata(tx_head),
    .count(tx_count),
    .full(tx_full),
    .empty(tx_empty)
  );

  // writes to a full or disabled transmitter are dropped
  assign tx_push = wr_tx & txen_q & ~tx_full;
  assign tx_start = (tx_st_q == TX_IDLE) & txen_q & (brk_q | ~tx_empty);
  assign tx_pop = tx_start & ~brk_q;
  assign tx_tick = tx_tmr_q == TICK_LAST;
  assign tx_last = brk_frame_q ? BREAK_ZEROS - 4'h1 : (fmt9 ? LAST_BIT_9 : LAST_BIT_8);
  assign tx_stop_end = (tx_st_q == TX_STOP) & tx_tick;
  assign brk_done = tx_stop_end & brk_frame_q;

  // transmit sequencer; a pending break goes ahead of queued data
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_st_q <= TX_IDLE;
      tx_tmr_q <= 16'h0000;
      tx_cnt_q <= 4'h0;
      tx_sh_q <= 9'h000;
      tx_par_q <= 1'b0;
      brk_frame_q <= 1'b0;
    end
    else if (!txen_q)
    begin
      tx_st_q <= TX_IDLE;
      tx_tmr_q <= 16'h0000;
      brk_frame_q <= 1'b0;
    end
    else
    begin
      tx_tmr_q <= (tx_st_q == TX_IDLE || tx_tick) ? 16'h0000 : tx_tmr_q + 16'h0001;
      case (tx_st_q)
        TX_IDLE:
          if (tx_start)
          begin
            tx_st_q <= TX_START;
            brk_frame_q <= brk_q;
            tx_sh_q <= brk_q ? 9'h000 : tx_head;
            tx_par_q <= (^tx_head[7:0]) ^ odd;
            tx_cnt_q <= 4'h0;
          end
        TX_START:
          if (tx_tick)
            tx_st_q <= TX_DATA;
        TX_DATA:
          if (tx_tick)
          begin
            tx_sh_q <= {1'b0, tx_sh_q[8:1]};
            if (tx_cnt_q == tx_last)
              tx_st_q <= (par_en && !brk_frame_q) ? TX_PAR : TX_STOP;
            else
              tx_cnt_q <= tx_cnt_q + 4'h1;
          end
        TX_PAR:
          if (tx_tick)
            tx_st_q <= TX_STOP;
        TX_STOP:
          if (tx_tick)
          begin
            tx_st_q <= TX_IDLE;
            brk_frame_q <= 1'b0;
          end
        default: tx_st_q <= TX_IDLE;
      endcase
    end
  end

  // line level before polarity and encoding
  always_comb
  begin
    case (tx_st_q)
      TX_START: tx_bit = 1'b0;
      TX_DATA: tx_bit = tx_sh_q[0];
      TX_PAR: tx_bit = tx_par_q;
      default: tx_bit = 1'b1;
    endcase
  end

  // pin stage: plain mode inverts only when txpol_q is set, infrared sends a short pulse per zero bit
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tx_pin_q <= 1'b1;
    else if (infrared_codec_enable_q)
      tx_pin_q <= (~tx_bit & (tx_tmr_q < IR_CLKS)) ? ~txpol_q : txpol_q;
    else
      tx_pin_q <= tx_bit ^ txpol_q;
  end
  assign serial_tx_pin_o = tx_pin_q;
  assign serial_tx_pin_oe = txen_q;

  // transmit event select; the reserved mode raises nothing
  always_comb
  begin
    case (txmode_q)
      TXM_EACH: tx_irq_d = tx_pop;
      TXM_EMPTY: tx_irq_d = tx_pop & (tx_count == CW'(1)) & ~tx_push;
      TXM_DONE: tx_irq_d = tx_stop_end & ~brk_frame_q & tx_empty & ~tx_push;
      default: tx_irq_d = 1'b0;
    endcase
  end

  // receive queue entry: parity error, framing error, nine data bits
  ustc_fifo #(.W(11), .DEPTH(FIFO_DEPTH)) u_rxq (
    .clk(pclk),
    .rst_n(presetn),
    .flush(overrun_flag_clr),
    .push(rx_push),
    .wdata({rx_parity_error_flag_q, ~serial_rx_pin, rx_sh_q}),
    .pop(rx_pop),
    .rdata(rx_head),
    .count(rx_count),
    .full(rx_full),
    .empty(rx_empty)
  );

  assign rx_tick = rx_tmr_q == TICK_LAST;
  assign rx_half = rx_tmr_q == HALF_LAST;
  assign rx_last = fmt9 ? LAST_BIT_9 : LAST_BIT_8;
  assign rx_done = (rx_st_q == RX_STOP) & rx_tick;
  assign rx_keep = ~(fmt9 & address_detect_enable_q & ~rx_sh_q[8]);
  // while overrun stands, finished characters are dropped
  assign rx_push = rx_done & rx_keep & ~rx_full & ~overrun_flag_q;
  assign ovf_evt = rx_done & rx_keep & rx_full & ~overrun_flag_q;
  assign rx_pop = rd_rx & ~rx_empty;
  assign rx_cnt_next = rx_count + CW'(rx_push) - CW'(rx_pop);

  // receive sequencer; start bit is checked at mid-bit to reject glitches
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_st_q <= RX_IDLE;
      rx_tmr_q <= 16'h0000;
      rx_cnt_q <= 4'h0;
      rx_sh_q <= 9'h000;
      rx_parity_error_flag_q <= 1'b0;
    end
    else if (overrun_flag_clr)
    begin
      rx_st_q <= RX_IDLE;
      rx_tmr_q <= 16'h0000;
    end
    else
    begin
      rx_tmr_q <= (rx_st_q == RX_IDLE || rx_tick || (rx_st_q == RX_START && rx_half)) ?
                  16'h0000 : rx_tmr_q + 16'h0001;
      case (rx_st_q)
        RX_IDLE:
          if (!serial_rx_pin)
          begin
            rx_st_q <= RX_START;
            rx_sh_q <= 9'h000;
            rx_cnt_q <= 4'h0;
            rx_parity_error_flag_q <= 1'b0;
          end
        RX_START:
          if (rx_half)
            rx_st_q <= serial_rx_pin ? RX_IDLE : RX_DATA;
        RX_DATA:
          if (rx_tick)
          begin
            rx_sh_q[rx_cnt_q] <= serial_rx_pin;
            if (rx_cnt_q == rx_last)
              rx_st_q <= par_en ? RX_PAR : RX_STOP;
            else
              rx_cnt_q <= rx_cnt_q + 4'h1;
          end
        RX_PAR:
          if (rx_tick)
          begin
            rx_parity_error_flag_q <= serial_rx_pin ^ (^rx_sh_q[7:0]) ^ odd;
            rx_st_q <= RX_STOP;
          end
        RX_STOP:
          if (rx_tick)
            rx_st_q <= RX_IDLE;
        default: rx_st_q <= RX_IDLE;
      endcase
    end
  end

  assign rx_irq_d = rx_push & (~rxmode_q[1] |
                    (rxmode_q == RXM_3Q && rx_cnt_next == RX_LVL_3Q) |
                    (rxmode_q == RXM_FULL && rx_cnt_next == RX_LVL_FULL));

  // event pulses leave from flip-flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_irq_q <= 1'b0;
      rx_irq_q <= 1'b0;
    end
    else
    begin
      tx_irq_q <= tx_irq_d;
      rx_irq_q <= rx_irq_d;
    end
  end
  assign tx_irq_o = tx_irq_q;
  assign rx_irq_o = rx_irq_q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_brk_zeros;
    brk_frame_q && tx_st_q == TX_DATA;
  endsequence

  property p_tx_each;
    txmode_q == TXM_EACH && tx_pop |=> tx_irq_o;
  endproperty
  a_tx_each: assert property (p_tx_each) else $error("no tx event on load");
  property p_tx_empty;
    txmode_q == TXM_EMPTY && tx_pop && !tx_push |=> tx_irq_o == ($past(tx_count) == CW'(1));
  endproperty
  a_tx_empty: assert property (p_tx_empty) else $error("wrong tx empty event");
  property p_tx_done;
    txmode_q == TXM_DONE && tx_irq_o |-> $past(tx_st_q == TX_STOP) && tx_st_q == TX_IDLE;
  endproperty
  a_tx_done: assert property (p_tx_done) else $error("tx done event too early");
  property p_tx_idle_level;
    tx_st_q == TX_IDLE && $past(tx_st_q == TX_IDLE) && !$past(infrared_codec_enable_q)
      |-> serial_tx_pin_o == ~$past(txpol_q);
  endproperty
  a_tx_idle_level: assert property (p_tx_idle_level) else $error("bad tx idle level");
  property p_brk_len;
    s_brk_zeros ##1 (brk_frame_q && tx_st_q == TX_STOP) |-> tx_cnt_q == BREAK_ZEROS - 4'h1;
  endproperty
  a_brk_len: assert property (p_brk_len) else $error("break length wrong");
  property p_brk_zero;
    s_brk_zeros |-> tx_bit == 1'b0;
  endproperty
  a_brk_zero: assert property (p_brk_zero) else $error("break bit not zero");
  property p_tx_off;
    !txen_q |-> !serial_tx_pin_oe ##1 (tx_st_q == TX_IDLE && tx_count == '0);
  endproperty
  a_tx_off: assert property (p_tx_off) else $error("tx disable did not abort");
  property p_rx_full_evt;
    rx_irq_o && $past(rxmode_q == RXM_FULL) |-> rx_count == RX_LVL_FULL;
  endproperty
  a_rx_full_evt: assert property (p_rx_full_evt) else $error("rx full event wrong");
  property p_rx_3q_evt;
    rx_irq_o && $past(rxmode_q == RXM_3Q) |-> rx_count == RX_LVL_3Q;
  endproperty
  a_rx_3q_evt: assert property (p_rx_3q_evt) else $error("rx 3/4 event wrong");
  property p_addr_drop;
    rx_done && fmt9 && address_detect_enable_q && !rx_sh_q[8] && !rx_pop |=> rx_count == $past(rx_count);
  endproperty
  a_addr_drop: assert property (p_addr_drop) else $error("data char kept");
  property p_ovf;
    rx_done && rx_keep && rx_full && !overrun_flag_clr |=> overrun_flag_q;
  endproperty
  a_ovf: assert property (p_ovf) else $error("overrun not flagged");
  property p_ovf_clr;
    overrun_flag_clr |=> rx_count == '0 && rx_st_q == RX_IDLE && !overrun_flag_q;
  endproperty
  a_ovf_clr: assert property (p_ovf_clr) else $error("overrun clear did not flush");

endmodule : ustc_core

// ==== logic/ustc_pkg.sv ====
package ustc_pkg;

  // register byte offsets on the apb bus
  localparam logic [11:0] ADDR_STATUS = 12'h000;
  localparam logic [11:0] ADDR_MODE = 12'h004;
  localparam logic [11:0] ADDR_TXDATA = 12'h008;
  localparam logic [11:0] ADDR_RXDATA = 12'h00C;

  // serial_status_control field positions
  localparam int BIT_TXMODE1 = 15;
  localparam int BIT_TXPOL = 14;
  localparam int BIT_TXMODE0 = 13;
  localparam int BIT_TXBRK = 11;
  localparam int BIT_TXEN = 10;
  localparam int BIT_TXFULL = 9;
  localparam int BIT_TXEMPTY = 8;
  localparam int BIT_RXMODE1 = 7;
  localparam int BIT_RXMODE0 = 6;
  localparam int BIT_ADDRESS_DETECT_ENABLE = 5;
  localparam int BIT_RX_IDLE_FLAG = 4;
  localparam int BIT_PARITY_ERROR_FLAG = 3;
  localparam int BIT_FRAMING_ERROR_FLAG = 2;
  localparam int BIT_OVERRUN_FLAG = 1;
  localparam int BIT_RXDA = 0;

  // mode register field positions
  localparam int BIT_INFRARED_CODEC_ENABLE = 12;
  localparam int BIT_FMT1 = 2;
  localparam int BIT_FMT0 = 1;

  // reset values of the writable fields
  localparam logic [15:0] STATUS_CTRL_RST = 16'h0000;
  localparam logic [15:0] MODE_RST = 16'h0000;

  // transmit interrupt modes
  localparam logic [1:0] TXM_EACH = 2'h0;
  localparam logic [1:0] TXM_DONE = 2'h1;
  localparam logic [1:0] TXM_EMPTY = 2'h2;
  localparam logic [1:0] TXM_RSVD = 2'h3;

  // receive interrupt modes and the fill levels they wait for
  localparam logic [1:0] RXM_3Q = 2'h2;
  localparam logic [1:0] RXM_FULL = 2'h3;
  localparam logic [2:0] RX_LVL_3Q = 3'h3;
  localparam logic [2:0] RX_LVL_FULL = 3'h4;

  // data formats
  localparam logic [1:0] FMT_8N = 2'h0;
  localparam logic [1:0] FMT_8E = 2'h1;
  localparam logic [1:0] FMT_8O = 2'h2;
  localparam logic [1:0] FMT_9N = 2'h3;

  // index of the last data bit of a frame; zero data bits in a break frame
  localparam logic [3:0] LAST_BIT_8 = 4'h7;
  localparam logic [3:0] LAST_BIT_9 = 4'h8;
  localparam logic [3:0] BREAK_ZEROS = 4'hC;

  // buffers and bit timing
  localparam int FIFO_DEPTH = 4;
  localparam int CLK_PERIOD_NS = 10;
  localparam int CLKS_PER_BIT_DEF = 16;
  localparam int IR_PULSE_NUM = 3;
  localparam int IR_PULSE_DEN = 16;

  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} ustc_tx_state_e;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} ustc_rx_state_e;

endpackage : ustc_pkg

// ==== logic/ustc_fifo.sv ====
module ustc_fifo
#(
  parameter int W = 9,
  parameter int DEPTH = 4
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic flush,
  // write side
  input wire logic push,
  input wire logic [W-1:0] wdata,
  // read side
  input wire logic pop,
  output logic [W-1:0] rdata,
  output logic [$clog2(DEPTH):0] count,
  output logic full,
  output logic empty
);

  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH)
  begin : g_bad_depth
    $error("ustc_fifo: DEPTH must be a power of two, at least 2");
  end

  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW-1:0] rd_ptr_d;
  logic [AW:0] count_q;
  logic [W-1:0] head_q;
  logic push_ok;
  logic pop_ok;

  // a push into a full queue and a pop from an empty one are dropped
  assign full = count_q == (AW + 1)'(DEPTH);
  assign empty = count_q == '0;
  assign push_ok = push & ~full;
  assign pop_ok = pop & ~empty;
  assign rd_ptr_d = pop_ok ? rd_ptr_q + 1'b1 : rd_ptr_q;
  assign count = count_q;
  assign rdata = head_q;

  // storage, no reset needed
  always_ff @(posedge clk)
  begin
    if (push_ok)
      mem_q[wr_ptr_q] <= wdata;
  end

  // pointers and fill level
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end
    else if (flush)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end
    else
    begin
      wr_ptr_q <= push_ok ? wr_ptr_q + 1'b1 : wr_ptr_q;
      rd_ptr_q <= rd_ptr_d;
      count_q <= count_q + (AW + 1)'(push_ok) - (AW + 1)'(pop_ok);
    end
  end

  // registered head; bypass when the new entry becomes the head at once
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      head_q <= '0;
    else if (flush)
      head_q <= '0;
    else
      head_q <= (push_ok && wr_ptr_q == rd_ptr_d) ? wdata : mem_q[rd_ptr_d];
  end

endmodule : ustc_fifo

// ==== verif/ustc_remote.sv ====
module ustc_remote
#(
  parameter int N = 8
)
(
  // clock shared with the port
  input wire logic clk,
  // serial lines seen from the far node
  input wire logic tx_line,
  output logic rx_line
);
  timeunit 1ns;
  timeprecision 1ps;
  int frames = 0;
  logic [7:0] got;

  // line rests high on its pull-up between frames
  initial rx_line = 1'b1;

  // decode each frame lsb first at mid-bit; garbage after an abort is harmless
  always
  begin
    @(negedge tx_line);
    repeat (N / 2) @(posedge clk);
    for (int i = 0; i < 8; i++)
    begin
      repeat (N) @(posedge clk);
      got[i] = tx_line;
    end
    repeat (N) @(posedge clk);
    frames++;
  end

  // one frame: start, nb data bits, optional parity, chosen stop level
  task automatic send(input logic [8:0] d, input int nb, input int par, input logic stop);
    rx_line <= 1'b0;
    repeat (N) @(posedge clk);
    for (int i = 0; i < nb; i++)
    begin
      rx_line <= d[i];
      repeat (N) @(posedge clk);
    end
    if (par >= 0)
    begin
      rx_line <= par[0];
      repeat (N) @(posedge clk);
    end
    rx_line <= stop;
    repeat (N) @(posedge clk);
    rx_line <= 1'b1;
    repeat (N) @(posedge clk);
  endtask : send
endmodule : ustc_remote

// ==== verif/tb.sv ====
module tb
  import ustc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int N = 8;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv, st;
  logic rx_line, tx_o, tx_oe, tx_irq, rx_irq;
  wire logic tx_line = tx_oe ? tx_o : 1'b1; // released pin rests on its pull-up
  int failures, samples_checked, tx_irqs, rx_irqs, run, maxrun, f0;
  int tx_exp[3] = '{5, 1, 2};
  int rx_exp[4] = '{4, 4, 1, 1};

  ustc_core #(.CLKS_PER_BIT(N)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .serial_rx_pin(rx_line), .serial_tx_pin_o(tx_o),
    .serial_tx_pin_oe(tx_oe), .tx_irq_o(tx_irq), .rx_irq_o(rx_irq));
  ustc_remote #(.N(N)) rem (.clk(pclk), .tx_line(tx_line), .rx_line(rx_line));

  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // pulses last one cycle, so count them at every edge; track longest low run
  always @(posedge pclk)
  begin
    if (tx_irq === 1'b1) tx_irqs++;
    if (rx_irq === 1'b1) rx_irqs++;
    run = (tx_line === 1'b0) ? run + 1 : 0;
    if (run > maxrun) maxrun = run;
  end

  // one apb transfer plus an idle cycle, so psel is never driven twice at one edge
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : xfer

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // poll the status word until bit b reaches v
  task automatic wait_flag(input int b, input logic v);
    int i;
    i = 0;
    do
    begin
      xfer(1'b0, ADDR_STATUS, 32'h0);
      i++;
    end
    while (rv[b] !== v && i < 400);
    // a flag that never settles is a hang and counts as a mismatch
    if (rv[b] !== v)
    begin
      failures++;
      $display("[ERR] flag %0d expected %b seen %b", b, v, rv[b]);
    end
  endtask : wait_flag

  task automatic final_report;
    if (failures == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : final_report

  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {failures, samples_checked, tx_irqs, rx_irqs, run, maxrun} = '0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    xfer(1'b0, ADDR_STATUS, 32'h0);
    chk("status", 32'h0110, rv);
    xfer(1'b0, 12'h010, 32'h0);
    chk("slverr", 32'h1, {31'h0, err});
    chk("pready", 32'h1, {31'h0, pready});
    // six writes: one shifts, four queue, the last is dropped; mode 11 is never set
    for (int m = 0; m < 3; m++)
    begin
      st = 32'({m[1], 1'b0, m[0], 13'h0400});
      xfer(1'b1, ADDR_STATUS, st);
      tx_irqs = 0;
      f0 = rem.frames;
      for (int k = 0; k < 6; k++) xfer(1'b1, ADDR_TXDATA, 32'hA0 + k);
      xfer(1'b0, ADDR_STATUS, 32'h0);
      chk("txfull", st | 32'h0210, rv);
      wait_flag(8, 1'b1);
      repeat (2 * N) @(posedge pclk);
      chk("frames", 5, rem.frames - f0);
      chk("txlast", 32'hA4, {24'h000000, rem.got});
      chk("txirq", tx_exp[m], tx_irqs);
    end
    xfer(1'b1, ADDR_STATUS, 32'h0C00);
    wait_flag(11, 1'b0);
    chk("break", 13 * N, maxrun);
    for (int k = 0; k < 3; k++) xfer(1'b1, ADDR_TXDATA, 32'h11);
    xfer(1'b1, ADDR_STATUS, 32'h0);
    xfer(1'b0, ADDR_STATUS, 32'h0);
    chk("abort", 32'h0110, rv);
    chk("oe", 32'h0, {31'h0, tx_oe});
    xfer(1'b1, ADDR_STATUS, 32'h4400);
    repeat (2) @(posedge pclk);
    chk("idle", 32'h0, {31'h0, tx_o});
    xfer(1'b1, ADDR_MODE, 32'h1000);
    repeat (2) @(posedge pclk);
    chk("iridle", 32'h1, {31'h0, tx_o});
    xfer(1'b1, ADDR_MODE, 32'h0);
    for (int r = 0; r < 4; r++)
    begin
      xfer(1'b1, ADDR_STATUS, 32'({r[1:0], 6'h00}));
      rx_irqs = 0;
      for (int k = 0; k < 4; k++) rem.send(9'h30 + k, 8, -1, 1'b1);
      chk("rxirq", rx_exp[r], rx_irqs);
      for (int k = 0; k < 4; k++)
      begin
        xfer(1'b0, ADDR_RXDATA, 32'h0);
        chk("rxdata", 32'h30 + k, rv);
      end
      xfer(1'b0, ADDR_STATUS, 32'h0);
      chk("rxempty", 32'h0110 | 32'({r[1:0], 6'h00}), rv);
    end
    for (int k = 0; k < 5; k++) rem.send(9'h40, 8, -1, 1'b1);
    xfer(1'b0, ADDR_STATUS, 32'h0);
    chk("ovr", 32'h01D3, rv);
    xfer(1'b1, ADDR_STATUS, 32'h0);
    xfer(1'b0, ADDR_STATUS, 32'h0);
    chk("ovrclr", 32'h0110, rv);
    xfer(1'b1, ADDR_MODE, 32'h2);
    rem.send(9'h55, 8, 1, 1'b1);
    rem.send(9'h0F, 8, 0, 1'b0);
    xfer(1'b0, ADDR_STATUS, 32'h0);
    chk("parity_error_flag", 32'h0119, rv);
    xfer(1'b0, ADDR_RXDATA, 32'h0);
    xfer(1'b0, ADDR_STATUS, 32'h0);
    chk("framing_error_flag", 32'h0115, rv);
    xfer(1'b0, ADDR_RXDATA, 32'h0);
    xfer(1'b1, ADDR_MODE, 32'h6);
    xfer(1'b1, ADDR_STATUS, 32'h20);
    rem.send(9'h055, 9, -1, 1'b1);
    rem.send(9'h1AA, 9, -1, 1'b1);
    xfer(1'b0, ADDR_RXDATA, 32'h0);
    chk("addr", 32'h1AA, rv);
    xfer(1'b0, ADDR_STATUS, 32'h0);
    chk("addrst", 32'h0130, rv);
    final_report;
  end

  // the whole run needs well under this many cycles
  initial
  begin
    repeat (60000) @(posedge pclk);
    failures++;
    final_report;
  end
endmodule : tb
